// file: design/deac_ctrl.sv
// Data EEPROM access controller: registers, unlock, read and program cycle
// Operation
// R1: 64 byte locations 0..3Fh, reached only through address and data.
// R2: Address register is 8 bits; upper two bits decoded, keep zero. Code ignores them, so addresses alias.
// R3: A byte write erases then programs the location, no erase command.
// R4: Write cycle length set by an internal timer, not software.
// R5: Processor access works while code protection blocks programmer.
// R6: Control bits 7:5 do not exist and read zero.
// R7: Read-start and program-start settable only; hardware clears them.
// R8: Program-permit bit 2 must be set for a write to proceed.
// R9: Power-up clears the program-permit bit.
// R10: Abort flag bit 3 set when pin or watchdog reset cuts a write.
// R11: Address and data survive an aborting reset for retry.
// R12: Done flag bit 4 set on write completion; software clears it.
// R13: Unlock register has no storage and reads zero.
// R14: Read-start bit 0 loads data register next cycle, clears itself.
// R15: Data register holds read byte until next read or software write.
// R16: Software loads address and data before the unlock sequence.
// R17: Write starts only after 55h, AAh to unlock, then program-start.
// R18: Program-start cannot be set while program-permit is clear.
// R19: Clearing program-permit during a write does not stop it.
// R20: New read or program starts are ignored during a write.
// R21: Timer length is a parameter; other writes reset unlock sequence.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module deac_ctrl
  import deac_pkg::*;
#(
  parameter logic [DEAC_TW-1:0] PROG_CYCLES = DEAC_TW'(DEAC_PROG_CYCLES)
) (
  // Clock, enable and resets
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic external_reset_pin,
  input wire logic watchdog_timer,
  // Code protection strap for the programmer path
  input wire logic code_protect,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Programmer access port
  input wire logic [5:0] prg_addr,
  output logic [7:0] prg_rdata,
  output logic prg_denied,
  // Status
  output logic prog_busy
);

  // ************************************************************
  // Pin synchronisers for the warm reset sources
  // ************************************************************
  logic [2:0] pin_sync_reg, pin_sync_next;
  logic [2:0] wdt_sync_reg, wdt_sync_next;
  logic pin_lvl_reg, pin_lvl_next;
  logic wdt_lvl_reg, wdt_lvl_next;
  logic warm_rst;

  // A level counts once the last two stages agree
  always_comb begin
    pin_sync_next = {pin_sync_reg[1:0], external_reset_pin};
    wdt_sync_next = {wdt_sync_reg[1:0], watchdog_timer};
    pin_lvl_next = pin_lvl_reg;
    wdt_lvl_next = wdt_lvl_reg;
    if (pin_sync_reg[1] == pin_sync_reg[2]) begin
      pin_lvl_next = pin_sync_reg[2];
    end
    if (wdt_sync_reg[1] == wdt_sync_reg[2]) begin
      wdt_lvl_next = wdt_sync_reg[2];
    end
  end

  // Either source acts as a warm reset of the controller
  assign warm_rst = pin_lvl_reg | wdt_lvl_reg;

  // ************************************************************
  // Request decode
  // ************************************************************
  deac_req_t req;
  assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

  logic wr_data, wr_addr, wr_ctrl, wr_unlock;
  always_comb begin
    wr_data = 1'b0;
    wr_addr = 1'b0;
    wr_ctrl = 1'b0;
    wr_unlock = 1'b0;
    if (req.wr && req.addr == DEAC_OFS_DATA) begin
      wr_data = 1'b1;
    end else if (req.wr && req.addr == DEAC_OFS_ADDR) begin
      wr_addr = 1'b1;
    end else if (req.wr && req.addr == DEAC_OFS_CTRL) begin
      wr_ctrl = 1'b1;
    end else if (req.wr && req.addr == DEAC_OFS_UNLOCK) begin
      wr_unlock = 1'b1;
    end
  end

  // ************************************************************
  // Storage array and working registers
  // ************************************************************
  logic [7:0] mem_reg [DEAC_DEPTH];
  logic [7:0] data_reg, data_next;
  logic [7:0] addr_reg, addr_next;
  logic permit_reg, permit_next;
  logic abort_reg, abort_next;
  logic done_reg, done_next;
  logic rd_pend_reg, rd_pend_next;
  logic pg_reg, pg_next;
  logic [DEAC_AW-1:0] pg_addr_reg, pg_addr_next;
  logic [7:0] pg_data_reg, pg_data_next;
  deac_unlock_t unl_reg, unl_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [7:0] prg_rdata_reg, prg_rdata_next;
  logic prg_denied_reg, prg_denied_next;
  logic tmr_start, tmr_done;
  logic [4:0] ctrl_view;

  // Unimplemented upper bits read as zero
  assign ctrl_view = {done_reg, abort_reg, permit_reg, pg_reg, rd_pend_reg}; // R6

  always_comb begin
    data_next = data_reg;
    addr_next = addr_reg;
    permit_next = permit_reg;
    abort_next = abort_reg;
    done_next = done_reg;
    rd_pend_next = 1'b0;
    pg_next = pg_reg;
    pg_addr_next = pg_addr_reg;
    pg_data_next = pg_data_reg;
    unl_next = unl_reg;
    tmr_start = 1'b0;

    // Unlock: any other register write breaks the sequence
    if (wr_unlock) begin
      if (req.wdata == DEAC_KEY_FIRST) begin
        unl_next = UNL_GOT1;
      end else if (req.wdata == DEAC_KEY_SECOND && unl_reg == UNL_GOT1) begin
        unl_next = UNL_ARMED; // R17
      end else begin
        unl_next = UNL_IDLE;
      end
    end else if (wr_data || wr_addr || wr_ctrl) begin
      unl_next = UNL_IDLE; // R21
    end

    if (wr_data) begin
      data_next = req.wdata; // R15
    end
    if (wr_addr) begin
      addr_next = req.wdata; // R2
    end

    if (wr_ctrl) begin
      permit_next = req.wdata[DEAC_BIT_PERMIT]; // R8 R19
      abort_next = req.wdata[DEAC_BIT_ABORT];
      // Software may clear done; a same-cycle completion still sets it
      done_next = req.wdata[DEAC_BIT_DONE]; // R12
      if (!pg_reg) begin // R20
        if (req.wdata[DEAC_BIT_RD_START]) begin
          rd_pend_next = 1'b1; // R7 R14
        end
        if (req.wdata[DEAC_BIT_PG_START] && permit_reg
            && unl_reg == UNL_ARMED) begin // R17 R18
          pg_next = 1'b1;
          pg_addr_next = addr_reg[DEAC_AW-1:0]; // R1
          pg_data_next = data_reg;
          tmr_start = 1'b1; // R4
        end
      end
    end

    // Read lands in the data register the cycle after it was set
    if (rd_pend_reg) begin
      data_next = mem_reg[addr_reg[DEAC_AW-1:0]]; // R14 R1
    end

    if (tmr_done) begin
      pg_next = 1'b0; // R7
      done_next = 1'b1; // R12
    end
  end

  // ************************************************************
  // Register read port
  // ************************************************************
  always_comb begin
    rdata_next = 8'h00;
    if (req.rd && req.addr == DEAC_OFS_DATA) begin
      rdata_next = data_reg;
    end else if (req.rd && req.addr == DEAC_OFS_ADDR) begin
      rdata_next = addr_reg;
    end else if (req.rd && req.addr == DEAC_OFS_CTRL) begin
      rdata_next = {3'h0, ctrl_view}; // R6
    end else if (req.rd && req.addr == DEAC_OFS_UNLOCK) begin
      rdata_next = 8'h00; // R13
    end
  end

  // Programmer path is cut off while code protection is on
  always_comb begin
    prg_denied_next = code_protect; // R5
    prg_rdata_next = 8'h00;
    if (!code_protect) begin
      prg_rdata_next = mem_reg[prg_addr];
    end
  end

  // ************************************************************
  // Program-cycle timer
  // ************************************************************
  deac_prog_timer #(
    .CYCLES(PROG_CYCLES) // R21
  ) u_timer (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .start(tmr_start),
    .abort(warm_rst),
    .busy(),
    .done(tmr_done)
  );

  // ************************************************************
  // State registers
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pin_sync_reg <= 3'h0;
      wdt_sync_reg <= 3'h0;
      pin_lvl_reg <= 1'b0;
      wdt_lvl_reg <= 1'b0;
    end else if (clk_en) begin
      pin_sync_reg <= pin_sync_next;
      wdt_sync_reg <= wdt_sync_next;
      pin_lvl_reg <= pin_lvl_next;
      wdt_lvl_reg <= wdt_lvl_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      data_reg <= DEAC_RST_BYTE;
      addr_reg <= DEAC_RST_BYTE;
      {done_reg, abort_reg, permit_reg, pg_reg, rd_pend_reg}
        <= DEAC_RST_CTRL; // R9
      pg_addr_reg <= '0;
      pg_data_reg <= DEAC_RST_BYTE;
      unl_reg <= UNL_IDLE;
      rdata_reg <= 8'h00;
      prg_rdata_reg <= 8'h00;
      prg_denied_reg <= 1'b0;
    end else if (clk_en && warm_rst) begin
      // Warm reset: address and data kept for a retry
      abort_reg <= abort_reg | pg_reg; // R10 R11
      permit_reg <= 1'b0;
      pg_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      unl_reg <= UNL_IDLE;
      rdata_reg <= 8'h00;
      // Programmer port is not part of the warm reset domain
      prg_rdata_reg <= prg_rdata_next;
      prg_denied_reg <= prg_denied_next;
    end else if (clk_en) begin
      data_reg <= data_next;
      addr_reg <= addr_next;
      permit_reg <= permit_next;
      abort_reg <= abort_next;
      done_reg <= done_next;
      rd_pend_reg <= rd_pend_next;
      pg_reg <= pg_next;
      pg_addr_reg <= pg_addr_next;
      pg_data_reg <= pg_data_next;
      unl_reg <= unl_next;
      rdata_reg <= rdata_next;
      prg_rdata_reg <= prg_rdata_next;
      prg_denied_reg <= prg_denied_next;
    end
  end

  // ************************************************************
  // Array update
  // ************************************************************
  // Erase and program collapse to one byte overwrite at cycle end
  // No reset here: stored bytes must survive every reset source
  always_ff @(posedge clk_sys) begin
    if (clk_en && tmr_done && !warm_rst) begin
      mem_reg[pg_addr_reg] <= pg_data_reg; // R3
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Every output is a flop, so no decode glitch reaches the pins
  assign reg_rdata = rdata_reg;
  assign prg_rdata = prg_rdata_reg;
  assign prg_denied = prg_denied_reg;
  assign prog_busy = pg_reg;

endmodule
`default_nettype wire

// file: design/deac_pkg.sv
// Package: register map, field layout and timing for the data EEPROM controller
package deac_pkg;

  // ************************************************************
  // Register offsets (8-bit register port)
  // ************************************************************
  localparam logic [7:0] DEAC_OFS_DATA = 8'h08;
  localparam logic [7:0] DEAC_OFS_ADDR = 8'h09;
  localparam logic [7:0] DEAC_OFS_CTRL = 8'h88;
  localparam logic [7:0] DEAC_OFS_UNLOCK = 8'h89;

  // ************************************************************
  // Control/status field positions
  // ************************************************************
  localparam int DEAC_BIT_RD_START = 0;
  localparam int DEAC_BIT_PG_START = 1;
  localparam int DEAC_BIT_PERMIT = 2;
  localparam int DEAC_BIT_ABORT = 3;
  localparam int DEAC_BIT_DONE = 4;
  localparam int DEAC_CTRL_WIDTH = 5;

  // ************************************************************
  // Array geometry, unlock keys, reset values, timing
  // ************************************************************
  localparam int DEAC_DEPTH = 64;
  localparam int DEAC_AW = 6;
  localparam logic [7:0] DEAC_KEY_FIRST = 8'h55;
  localparam logic [7:0] DEAC_KEY_SECOND = 8'haa;
  localparam logic [7:0] DEAC_RST_BYTE = 8'h00;
  localparam logic [4:0] DEAC_RST_CTRL = 5'h00;
  localparam int DEAC_CLK_MHZ = 250;
  localparam int DEAC_PROG_TIME_US = 4;
  localparam int DEAC_PROG_CYCLES = DEAC_PROG_TIME_US * DEAC_CLK_MHZ;
  localparam int DEAC_TW = 16;

  // Unlock sequence states
  typedef enum logic [2:0] {
    UNL_IDLE = 3'b001,
    UNL_GOT1 = 3'b010,
    UNL_ARMED = 3'b100
  } deac_unlock_t;

  // Register port request bundle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } deac_req_t;

endpackage

// file: design/deac_prog_timer.sv
// Program-cycle timer: counts a write cycle from start to done
`timescale 1ns/1ps
`default_nettype none
module deac_prog_timer
  import deac_pkg::*;
#(
  parameter logic [DEAC_TW-1:0] CYCLES = DEAC_TW'(DEAC_PROG_CYCLES)
) (
  // Clock and control
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Timer handshake
  input wire logic start,
  input wire logic abort,
  output logic busy,
  output logic done
);
  logic [DEAC_TW-1:0] cnt_reg, cnt_next;
  logic busy_reg, busy_next;
  logic done_reg, done_next;

  always_comb begin
    cnt_next = cnt_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (abort) begin
      busy_next = 1'b0;
      cnt_next = '0;
    end else if (busy_reg) begin
      if (cnt_reg == CYCLES - 1'b1) begin
        busy_next = 1'b0;
        done_next = 1'b1;
        cnt_next = '0;
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end else if (start) begin
      busy_next = 1'b1;
      cnt_next = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (clk_en) begin
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign busy = busy_reg;
  assign done = done_reg;
endmodule
`default_nettype wire

// file: verif/deac_ctrl_properties.sv
// Checker for the data EEPROM controller ports
`timescale 1ns/1ps
`default_nettype none
module deac_ctrl_properties
  import deac_pkg::*;
#(
  parameter logic [DEAC_TW-1:0] PROG_CYCLES = DEAC_TW'(DEAC_PROG_CYCLES)
) (
  // Clock and resets
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic external_reset_pin,
  input wire logic watchdog_timer,
  input wire logic code_protect,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Programmer port and status
  input wire logic [5:0] prg_addr,
  input wire logic [7:0] prg_rdata,
  input wire logic prg_denied,
  input wire logic prog_busy
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic [DEAC_TW:0] run_reg, run_next;
  logic go_reg, go_next;
  // Busy run length and the start request of the previous cycle
  always_comb begin
    run_next = sys_rst || !prog_busy ? '0 : clk_en ? run_reg + 1'b1 : run_reg;
    go_next = clk_en && reg_wr && reg_addr == DEAC_OFS_CTRL &&
      reg_wdata[DEAC_BIT_PG_START];
  end
  always_ff @(posedge clk_sys) begin
    run_reg <= run_next;
    go_reg <= go_next;
  end
  a_rdata_idle: assert property (
    clk_en && !reg_rd |=> reg_rdata == 8'h00) else $error("stray read data");
  a_unlock_zero: assert property (
    clk_en && reg_rd && reg_addr == DEAC_OFS_UNLOCK |=> reg_rdata == 8'h00)
    else $error("unlock port read not zero");
  a_ctrl_upper: assert property (
    clk_en && reg_rd && reg_addr == DEAC_OFS_CTRL |=> reg_rdata[7:5] == 3'h0)
    else $error("control upper bits not zero");
  a_busy_len: assert property (prog_busy |-> run_reg <= PROG_CYCLES)
    else $error("write cycle too long");
  a_freeze_hold: assert property (
    !clk_en |=> $stable(prog_busy) && $stable(reg_rdata))
    else $error("state moved while enable low");
  a_busy_cause: assert property ($rose(prog_busy) |-> go_reg)
    else $error("write began without a start request");
  a_prot_flag: assert property (
    clk_en |=> prg_denied == $past(code_protect))
    else $error("denied flag wrong");
  a_prot_blank: assert property (
    clk_en && code_protect |=> prg_rdata == 8'h00)
    else $error("protected data visible");
  a_pin_abort: assert property (
    (external_reset_pin && clk_en)[*7] |-> !prog_busy)
    else $error("pin reset did not stop the write");
  a_wdt_abort: assert property (
    (watchdog_timer && clk_en)[*7] |-> !prog_busy)
    else $error("watchdog reset did not stop the write");
  c_prog_run: cover property ($fell(prog_busy));
  c_mem_read: cover property (reg_rd && reg_addr == DEAC_OFS_DATA);
  c_abort: cover property (external_reset_pin && prog_busy);
endmodule
bind deac_ctrl deac_ctrl_properties #(.PROG_CYCLES(PROG_CYCLES)) u_props (
  .clk_sys, .sys_rst, .clk_en, .external_reset_pin, .watchdog_timer,
  .code_protect, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .prg_addr, .prg_rdata, .prg_denied, .prog_busy);
`default_nettype wire

// file: verif/test_deac_ctrl.sv
// Self-checking bench for the data EEPROM controller
`timescale 1ns/1ps
`default_nettype none
module test_deac_ctrl;
  import deac_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic ext_rst = 1'b0, wdt_rst = 1'b0, code_protect = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, prg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, prg_denied, prog_busy;
  logic [5:0] prg_addr = 6'h00;
  logic [7:0] mem [DEAC_DEPTH];
  logic [7:0] a, d;
  logic [7:0] bk1 [4] = '{8'h55, 8'haa, 8'h55, 8'h55};
  logic [7:0] bk2 [4] = '{8'haa, 8'h55, 8'h5a, 8'haa};
  logic [7:0] bpre [4] = '{8'h00, 8'h04, 8'h04, 8'h04};
  logic [31:0] seed = 32'h0065;
  int miscompares = 0, comparisons = 0;
  always #2 clk_sys = ~clk_sys;
  // Short write cycle keeps the run brief
  deac_ctrl #(.PROG_CYCLES(DEAC_TW'(16))) u_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
    .external_reset_pin(ext_rst), .watchdog_timer(wdt_rst),
    .code_protect(code_protect), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .prg_addr(prg_addr), .prg_rdata(prg_rdata),
    .prg_denied(prg_denied), .prog_busy(prog_busy));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [7:0] ctl(input logic done, abt, perm);
    return {3'h0, done, abt, perm, 2'b00};
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] ad, dt);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= dt;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [7:0] ad, exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(what, exp, reg_rdata);
  endtask
  task automatic mchk(input logic [7:0] ad);
    wr(DEAC_OFS_ADDR, ad);
    wr(DEAC_OFS_CTRL, 8'h01);
    rchk("mem", DEAC_OFS_DATA, mem[ad[5:0]]);
  endtask
  // A data write between the keys breaks the unlock
  task automatic prog(input logic [7:0] ad, dt, k1, k2, pre, input logic brk);
    wr(DEAC_OFS_ADDR, ad);
    wr(DEAC_OFS_DATA, dt);
    wr(DEAC_OFS_CTRL, pre);
    wr(DEAC_OFS_UNLOCK, k1);
    if (brk) wr(DEAC_OFS_DATA, dt);
    wr(DEAC_OFS_UNLOCK, k2);
    wr(DEAC_OFS_CTRL, pre | 8'h02);
    #1 chk("busy", {7'h0, pre[2] && !brk && k1 == 8'h55 && k2 == 8'haa},
      {7'h0, prog_busy});
  endtask
  task automatic idle();
    for (int n = 0; n < 64 && prog_busy !== 1'b0; n++) begin
      @(posedge clk_sys);
      #1;
    end
    chk("busy end", 8'h00, {7'h0, prog_busy});
  endtask
  task automatic end_of_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk_sys);
    miscompares++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rchk("ctrl", DEAC_OFS_CTRL, 8'h00);
    rchk("unlock", DEAC_OFS_UNLOCK, 8'h00);
    rchk("unmapped", 8'h10, 8'h00);
    for (int i = 0; i < DEAC_DEPTH; i++) begin
      seed = xs(seed);
      mem[i] = seed[7:0];
      prog(8'(i), mem[i], 8'h55, 8'haa, 8'h04, 1'b0);
      idle();
      rchk("ctrl", DEAC_OFS_CTRL, ctl(1'b1, 1'b0, 1'b1));
    end
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      mchk(seed[7:0]);
      rchk("hold", DEAC_OFS_DATA, mem[seed[5:0]]);
    end
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      prog(seed[7:0], ~mem[seed[5:0]], bk1[k], bk2[k], bpre[k], k == 3);
      mchk(seed[7:0]);
    end
    seed = xs(seed);
    d = ~mem[seed[5:0]];
    prog(seed[7:0], d, 8'h55, 8'haa, 8'h04, 1'b0);
    wr(DEAC_OFS_CTRL, 8'h01);
    wr(DEAC_OFS_CTRL, 8'h00);
    rchk("ctrl busy", DEAC_OFS_CTRL, 8'h02);
    idle();
    mem[seed[5:0]] = d;
    rchk("data kept", DEAC_OFS_DATA, d);
    rchk("ctrl", DEAC_OFS_CTRL, ctl(1'b1, 1'b0, 1'b0));
    mchk(seed[7:0]);
    for (int s = 0; s < 2; s++) begin
      seed = xs(seed);
      a = {2'b00, seed[5:0]};
      d = ~mem[a[5:0]];
      prog(a, d, 8'h55, 8'haa, 8'h04, 1'b0);
      @(posedge clk_sys);
      ext_rst <= s == 0;
      wdt_rst <= s == 1;
      repeat (8) @(posedge clk_sys);
      ext_rst <= 1'b0;
      wdt_rst <= 1'b0;
      repeat (8) @(posedge clk_sys);
      rchk("ctrl abort", DEAC_OFS_CTRL, ctl(1'b0, 1'b1, 1'b0));
      rchk("addr kept", DEAC_OFS_ADDR, a);
      rchk("data kept", DEAC_OFS_DATA, d);
      wr(DEAC_OFS_CTRL, 8'h00);
      rchk("ctrl clear", DEAC_OFS_CTRL, 8'h00);
      mchk(a);
    end
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      @(posedge clk_sys);
      prg_addr <= seed[5:0];
      code_protect <= seed[8];
      repeat (2) @(posedge clk_sys);
      #1 chk("prog port", seed[8] ? 8'h00 : mem[seed[5:0]], prg_rdata);
      chk("denied", {7'h0, seed[8]}, {7'h0, prg_denied});
      mchk(seed[7:0]);
    end
    // Protected write, stretched by a frozen enable, must still land
    code_protect <= 1'b1;
    seed = xs(seed);
    a = {2'b00, seed[5:0]};
    d = ~mem[a[5:0]];
    prog(a, d, DEAC_KEY_FIRST, DEAC_KEY_SECOND, 8'h04, 1'b0);
    clk_en <= 1'b0;
    wr(DEAC_OFS_ADDR, ~a);
    repeat (40) @(posedge clk_sys);
    clk_en <= 1'b1;
    #1 chk("frozen busy", 8'h01, {7'h0, prog_busy});
    idle();
    mem[a[5:0]] = d;
    rchk("addr frozen", DEAC_OFS_ADDR, a);
    mchk(a);
    end_of_test();
  end
endmodule
`default_nettype wire
